// ### sim/sac_adc_ctrl_tb.sv
// Purpose: self-checking bench of the converter sequencer
// Assumes: conversion clock is pclk/2 (divide select 1) unless async or alternate source
// Notes:   front end model holds the input while isolated
`timescale 1ns/1ps
`default_nettype none
module sac_adc_ctrl_tb
  import sac_pkg::*;
;
  localparam int AD = 2;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        hw_trig_pin, stop_pin, fe_compare, fe_sample, fe_active;
  logic        fe_low_power, async_clk_en, irq;
  logic [4:0]  fe_channel;
  logic [9:0]  fe_trial, vin;
  int          err_total, num_checks, n, w, p;
  int          cyc = 0;
  sac_adc_ctrl #(.ALT_DIV(4), .ASYNC_DIV(AD)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hw_trig_pin(hw_trig_pin),
    .stop_pin(stop_pin), .fe_compare(fe_compare),
    .fe_channel(fe_channel), .fe_sample(fe_sample),
    .fe_active(fe_active), .fe_trial(fe_trial),
    .fe_low_power(fe_low_power), .async_clk_en(async_clk_en), .irq(irq));
  sac_fe_model u_fe (
    .pclk(pclk), .presetn(presetn), .fe_sample(fe_sample),
    .fe_active(fe_active), .fe_trial(fe_trial), .vin(vin),
    .fe_compare(fe_compare));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      $display("Error at %0t: timeout got %h exp %h", $time, cyc, 0);
      end_of_test;
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  // on failure the nearer bound is shown as the expected value
  task rng(input int v, input int lo, input int hi);
    chk(32'(v), 32'((v < lo) ? lo : (v > hi) ? hi : v));
  endtask : rng
  task rw(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask : rw
  // s selects fe_sample, else irq; counts edges until level v
  task wfor(input logic s, input logic v, output int k);
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while ((s ? fe_sample : irq) !== v && k < 3000);
  endtask : wfor
  task res(input logic m, input logic [9:0] v);
    rw(1'b0, RESH_OFF, 32'h0);
    chk(rd, m ? {30'h0, v[9:8]} : 32'h0);
    rw(1'b0, RESL_OFF, 32'h0);
    chk(rd, m ? {24'h0, v[7:0]} : {24'h0, v[9:2]});
  endtask : res
  task t_reset;
    chk(fe_channel, 5'h1f);
    chk({fe_active, irq, async_clk_en}, 3'h0);
    rw(1'b0, 8'h20, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    $display("reset test done");
  endtask : t_reset
  task t_first;
    logic m;
    logic l;
    int   e;
    rw(1'b1, IMSK_OFF, 32'h1);
    for (int i = 0; i < 4; i++) begin
      m = i[0];
      l = i[1];
      e = ((l ? 40 : 20) + (m ? 3 : 0)) * 2;
      vin <= 10'h2a5 - 10'(i * 7);
      rw(1'b1, IST_OFF, 32'h3);
      rw(1'b1, CFG_OFF, {24'h0, 3'b001, l, 1'b0, m, 2'h0});
      rw(1'b1, SC1_OFF, 32'h41);
      wfor(1'b0, 1'b1, n);
      rng(n, e, e + 6);
      rw(1'b0, SC1_OFF, 32'h0);
      chk(rd[7], 1'b1);
      res(m, vin);
    end
    $display("first conversion test done");
  endtask : t_first
  task t_cont;
    logic m;
    logic l;
    for (int i = 0; i < 4; i++) begin
      m = i[0];
      l = i[1];
      rw(1'b1, CFG_OFF, {24'h0, 3'b001, l, 1'b0, m, 2'h0});
      rw(1'b1, SC1_OFF, 32'h21);
      wfor(1'b1, 1'b1, n);
      wfor(1'b1, 1'b0, n);
      wfor(1'b1, 1'b1, n);
      wfor(1'b1, 1'b0, w);
      wfor(1'b1, 1'b1, p);
      chk(32'(w), l ? 32'h30 : 32'h8);
      chk(32'(p + w), 32'(((l ? 37 : 17) + (m ? 3 : 0)) * 2));
      rw(1'b1, SC1_OFF, 32'h1f);
    end
    $display("continuous test done");
  endtask : t_cont
  task t_abort;
    rw(1'b1, CFG_OFF, 32'h34);
    vin <= 10'h155;
    rw(1'b1, IST_OFF, 32'h3);
    rw(1'b1, SC1_OFF, 32'h41);
    wfor(1'b0, 1'b1, n);
    rw(1'b1, IST_OFF, 32'h3);
    vin <= 10'h0aa;
    rw(1'b1, SC1_OFF, 32'h41);
    repeat (30) @(posedge pclk);
    rw(1'b1, CMP_OFF, 32'h3ff);
    repeat (3) @(posedge pclk);
    chk(fe_active, 1'b0);
    res(1'b1, 10'h155);
    rw(1'b0, IST_OFF, 32'h0);
    chk(rd, 32'h2);
    chk(irq, 1'b0);
    rw(1'b1, IMSK_OFF, 32'h3);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b1);
    rw(1'b1, IST_OFF, 32'h2);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    rw(1'b1, IMSK_OFF, 32'h1);
    $display("abort and interrupt test done");
  endtask : t_abort
  task t_stop;
    rw(1'b1, CFG_OFF, 32'h20);
    rw(1'b1, SC1_OFF, 32'h41);
    repeat (8) @(posedge pclk);
    stop_pin <= 1'b1;
    repeat (8) @(posedge pclk);
    chk(fe_active, 1'b0);
    rw(1'b1, CFG_OFF, 32'h07);
    rw(1'b1, IST_OFF, 32'h3);
    vin <= 10'h3c1;
    rw(1'b1, SC1_OFF, 32'h41);
    repeat (3) @(posedge pclk);
    chk(async_clk_en, 1'b1);
    wfor(1'b0, 1'b1, n);
    rng(n + 3, ASYNC_START_CYC + 46, ASYNC_START_CYC + 56);
    res(1'b1, 10'h3c1);
    stop_pin <= 1'b0;
    $display("stop test done");
  endtask : t_stop
  task t_misc;
    rw(1'b1, CFG_OFF, 32'ha0);
    repeat (2) @(posedge pclk);
    chk(fe_low_power, 1'b1);
    rw(1'b1, SC2_OFF, 32'h40);
    rw(1'b1, IST_OFF, 32'h3);
    vin <= 10'h077;
    rw(1'b1, SC1_OFF, 32'h41);
    repeat (6) @(posedge pclk);
    chk(fe_active, 1'b0);
    hw_trig_pin <= 1'b1;
    wfor(1'b0, 1'b1, n);
    rng(n, 40, 54);
    res(1'b0, 10'h077);
    hw_trig_pin <= 1'b0;
    // alternate source, divide 4: four pclk per conversion clock
    rw(1'b1, SC2_OFF, 32'h0);
    rw(1'b1, CFG_OFF, 32'h02);
    rw(1'b1, IST_OFF, 32'h3);
    rw(1'b1, SC1_OFF, 32'h41);
    wfor(1'b0, 1'b1, n);
    rng(n, 80, 86);
    res(1'b0, 10'h077);
    $display("trigger and low power test done");
  endtask : t_misc
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {hw_trig_pin, stop_pin, vin, err_total, num_checks} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_first;
    t_cont;
    t_abort;
    t_stop;
    t_misc;
    end_of_test;
  end
endmodule : sac_adc_ctrl_tb
`default_nettype wire

// ### sim/sac_fe_model.sv
// Purpose: analog sample and compare front end of the converter
// Assumes: the analog input arrives as a 10-bit code from the bench
// Notes:   comparator output toggles each cycle while powered down
`timescale 1ns/1ps
`default_nettype none
module sac_fe_model (
  input  wire logic       pclk,       // bus clock
  input  wire logic       presetn,    // async reset, active low
  input  wire logic       fe_sample,  // sample switch closed
  input  wire logic       fe_active,  // front end powered
  input  wire logic [9:0] fe_trial,   // trial code
  input  wire logic [9:0] vin,        // analog input as a code
  output logic            fe_compare  // held input >= trial
);
  logic [9:0] held;
  logic       junk;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held <= 10'h000;
      junk <= 1'b0;
    end else begin
      junk <= ~junk;
      if (fe_sample) begin
        held <= vin;
      end
    end
  end
  // input isolated after sampling, so the held level is compared
  assign fe_compare = fe_active ? (held >= fe_trial) : junk;
endmodule : sac_fe_model
`default_nettype wire

// ### verilog/sac_adc_ctrl.sv
// Purpose: sequencer and APB registers of a 10-bit SAR converter
// Assumes: analog front end compares on pclk; pins are asynchronous
// Notes:   result words read back as zero in unused upper bits
// Functional notes
// (RULE1) stay idle until a start occurs
// (RULE2) enable async clock when active
// (RULE3) low power setting limits conversion clock
// (RULE4) sample, then isolate and approximate
// (RULE5) transfer result at end of approximation
// (RULE6) first short: 20 or 23 ticks
// (RULE7) first long: 40 or 43 ticks
// (RULE8) async source adds 5 us start-up
// (RULE9) later short: 17 or 20 ticks
// (RULE10) later long: 37 or 40 ticks
// (RULE11) exact continuous timing needs fast bus
// (RULE12) clock from source select then divider
// (RULE13) sample window short 3.5, long 23.5; the code samples for 4 and 24 ticks
// (RULE14) software waits and keeps pins quiet
// (RULE15) async clock keeps converting in stop
// (RULE16) completion sets flag, maybe interrupt
// (RULE17) mode register write aborts, result kept
// (RULE18) stop without async clock aborts
// (RULE19) start and finish synchronisation in overhead
//
// The address map and the APB register port were left to the implementer.

`timescale 1ns/1ps
`default_nettype none

module sac_adc_ctrl
  import sac_pkg::*;
#(
  parameter int ALT_DIV   = 4,
  parameter int ASYNC_DIV = 2
) (
  input  wire logic        pclk,         // bus clock
  input  wire logic        presetn,      // async reset, active low
  input  wire logic        psel,         // apb select
  input  wire logic        penable,      // apb enable
  input  wire logic        pwrite,       // apb direction
  input  wire logic [7:0]  paddr,        // apb byte address
  input  wire logic [31:0] pwdata,       // apb write data
  output logic      [31:0] prdata,       // apb read data
  output logic             pready,       // apb ready
  output logic             pslverr,      // apb error, unmapped
  input  wire logic        hw_trig_pin,  // hardware trigger pin
  input  wire logic        stop_pin,     // stop mode request pin
  input  wire logic        fe_compare,   // comparator: input >= trial
  output logic      [4:0]  fe_channel,   // selected input
  output logic             fe_sample,    // sample switch closed
  output logic             fe_active,   // front end powered
  output logic      [9:0]  fe_trial,     // trial code to dac
  output logic             fe_low_power, // low_power_conv_sel
  output logic             async_clk_en, // async_conv_clock enable
  output logic             irq           // interrupt, active high
);

  typedef struct packed {
    logic          pready;
    logic [31:0]   prdata;
    logic          pslverr;
    logic [1:0]    s1;
    logic [1:0]    s2;
    logic [1:0]    s3;
    logic [1:0]    lvl;
    logic          trig_d;
    logic [4:0]    chan;
    logic          cont;
    logic          ie;
    logic          conv_complete_flag;
    logic          hwtrg;
    logic [1:0]    clk_sel;
    logic [1:0]    div;
    logic          mode10;
    logic          long_smp;
    logic          lowp;
    logic [9:0]    cmp;
    logic [9:0]    result;
    logic [1:0]    ist;
    logic [1:0]    imsk;
    sac_state_type state;
    logic [5:0]    cnt;
    logic [3:0]    bitn;
    logic [9:0]    trial;
    logic          first;
    logic          sample;
    logic          active;
    logic          run;
    logic          irq;
  } sac_ctrl_type;

  localparam sac_ctrl_type RST_STATE = '{
    chan:    CHAN_OFF,
    state:   ST_IDLE,
    default: '0
  };

  sac_ctrl_type s;
  sac_ctrl_type n;
  logic         tick;
  logic         async_ready;
  logic         done_w;
  logic         abort_w;
  logic         wmode_w;

  sac_clkgen #(
    .ALT_DIV   (ALT_DIV),
    .ASYNC_DIV (ASYNC_DIV)
  ) u_clkgen (
    .pclk        (pclk),
    .presetn     (presetn),
    .run         (s.run),
    .clk_sel     (s.clk_sel),
    .div_sel     (s.div),
    .low_power   (s.lowp),
    .tick        (tick),
    .async_en    (async_clk_en),
    .async_ready (async_ready)
  );

  function automatic logic sac_hit(input logic [7:0] a,
                                   input logic [7:0] off);
    return a == off;
  endfunction : sac_hit

  always_comb begin
    logic        acc;
    logic        wr;
    logic        rd;
    logic        trig_rise;
    logic        stop;
    logic        start;
    logic [31:0] rdat;
    logic        hit;
    acc       = psel && penable;
    wr        = acc && s.pready && pwrite;
    rd        = acc && s.pready && !pwrite;
    n         = s;
    done_w    = 1'b0;
    abort_w   = 1'b0;
    wmode_w   = 1'b0;
    start     = 1'b0;
    rdat      = 32'h0;
    hit       = 1'b1;
    trig_rise = s.lvl[0] && !s.trig_d;
    stop      = s.lvl[1];

    // pin synchronisers: a change counts when stages two and three agree
    n.s1 = {stop_pin, hw_trig_pin};
    n.s2 = s.s1;
    n.s3 = s.s2;
    for (int i = 0; i < 2; i++) begin
      if (s.s2[i] == s.s3[i])
        n.lvl[i] = s.s3[i];
    end
    n.trig_d  = s.lvl[0];

    unique case (paddr)
      SC1_OFF:  rdat = {24'h0, s.conv_complete_flag, s.ie, s.cont, s.chan};
      SC2_OFF:  rdat = {24'h0, s.state != ST_IDLE, s.hwtrg, 5'h0,
                        async_ready};
      CFG_OFF:  rdat = {24'h0, s.lowp, s.div, s.long_smp, 1'b0, s.mode10,
                        s.clk_sel};
      CMP_OFF:  rdat = {22'h0, s.cmp};
      RESH_OFF: rdat = {30'h0, s.result[9:8]};
      RESL_OFF: rdat = {24'h0, s.result[7:0]};
      IST_OFF:  rdat = {30'h0, s.ist};
      IMSK_OFF: rdat = {30'h0, s.imsk};
      default:  hit  = 1'b0;
    endcase
    n.pready  = acc && !s.pready;
    n.pslverr = acc && !s.pready && !hit;
    n.prdata  = (acc && !s.pready && !pwrite) ? rdat : 32'h0;

    // reading the low result word releases the completion flag
    if (rd && sac_hit(paddr, RESL_OFF))
      n.conv_complete_flag = 1'b0;

    if (wr) begin
      unique case (paddr)
        SC1_OFF: begin
          n.chan = pwdata[4:0];
          n.cont = pwdata[SC1_CONT_BIT];
          n.ie   = pwdata[SC1_IE_BIT];
          n.conv_complete_flag = 1'b0;
        end
        SC2_OFF: n.hwtrg = pwdata[SC2_HWT_BIT];
        CFG_OFF: begin
          n.clk_sel  = pwdata[1:0];
          n.mode10   = pwdata[CFG_MODE_BIT];
          n.long_smp = pwdata[CFG_LS_BIT];
          n.div      = pwdata[CFG_DIV_LSB +: 2];
          n.lowp     = pwdata[CFG_LP_BIT];
        end
        CMP_OFF:  n.cmp  = pwdata[9:0];
        IST_OFF:  n.ist  = s.ist & ~pwdata[1:0];
        IMSK_OFF: n.imsk = pwdata[1:0];
        default:  n.imsk = s.imsk;
      endcase
    end

    wmode_w = wr && (sac_hit(paddr, SC2_OFF) || sac_hit(paddr, CFG_OFF)
                     || sac_hit(paddr, CMP_OFF)); // RULE17
    // with the async source selected the sequence runs on through stop
    abort_w = wmode_w || (wr && sac_hit(paddr, SC1_OFF))
              || (stop && s.clk_sel != CLK_ASYNC); // RULE15 RULE18

    if (abort_w) begin
      // results are left as the last completed conversion wrote them
      if (s.state != ST_IDLE)
        n.ist[1] = 1'b1; // RULE17
      n.state = ST_IDLE;
    end else begin
      unique case (s.state)
        ST_IDLE: n.state = ST_IDLE; // RULE1
        ST_SYNC: begin
          if (s.cnt == 6'(START_SYNC_CYC - 1)) begin
            n.state = ST_WAKE; // RULE19
            n.cnt   = 6'h00;
          end else begin
            n.cnt = s.cnt + 6'h01;
          end
        end
        ST_WAKE: begin
          if (tick) begin
            if (s.cnt == FIRST_EXTRA_TICKS - 6'h01) begin
              n.state = ST_SAMPLE; // RULE6 RULE7 RULE8
              n.cnt   = 6'h00;
            end else begin
              n.cnt = s.cnt + 6'h01;
            end
          end
        end
        ST_SAMPLE: begin
          if (tick) begin
            n.cnt = s.cnt + 6'h01;
            if (s.cnt == sac_smp_ticks(s.long_smp) - 6'h01) begin
              n.state = ST_APPROX; // RULE4 RULE13
              n.trial = 10'h200;
              n.bitn  = 4'h9;
            end
          end
        end
        ST_APPROX: begin
          if (tick) begin
            n.cnt = s.cnt + 6'h01;
            if (!fe_compare)
              n.trial[s.bitn] = 1'b0; // RULE4
            if (s.bitn == (s.mode10 ? 4'h0 : 4'h2)) begin
              n.state = ST_PAD;
            end else begin
              n.bitn            = s.bitn - 4'h1;
              n.trial[n.bitn]   = 1'b1;
            end
          end
        end
        ST_PAD: begin
          if (tick) begin
            if (s.cnt == sac_sub_ticks(s.mode10, s.long_smp) - 6'h01)
            begin
              done_w   = 1'b1; // RULE9 RULE10
              n.result = s.mode10 ? s.trial
                                  : {2'b00, s.trial[9:2]}; // RULE5
              n.conv_complete_flag   = 1'b1; // RULE16
              if (s.ie)
                n.ist[0] = 1'b1; // RULE16
              n.cnt   = 6'h00;
              n.first = 1'b0;
              // next sample starts on the very next tick
              n.state = s.cont ? ST_SAMPLE : ST_IDLE; // RULE11
            end else begin
              n.cnt = s.cnt + 6'h01;
            end
          end
        end
        default: n.state = ST_IDLE;
      endcase
    end

    if (!(stop && s.clk_sel != CLK_ASYNC)) begin
      if (wr && sac_hit(paddr, SC1_OFF) && !s.hwtrg)
        start = pwdata[4:0] != CHAN_OFF;
      else if (s.hwtrg && trig_rise && s.state == ST_IDLE)
        start = s.chan != CHAN_OFF;
    end
    if (start) begin
      n.state = ST_SYNC; // RULE19
      n.cnt   = 6'h00;
      n.first = 1'b1;
    end

    n.run    = n.state != ST_IDLE; // RULE1 RULE2
    n.active = n.state != ST_IDLE;
    n.sample = n.state == ST_SAMPLE;
    n.irq    = |(n.ist & n.imsk);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      s <= RST_STATE;
    else
      s <= n;
  end

  assign prdata       = s.prdata;
  assign pready       = s.pready;
  assign pslverr      = s.pslverr;
  assign fe_channel   = s.chan;
  assign fe_sample    = s.sample;
  assign fe_active    = s.active;
  assign fe_trial     = s.trial;
  assign fe_low_power = s.lowp;
  assign irq          = s.irq;

  // ticks since the start of the conversion, and pclk since the start
  logic [6:0] h_ticks;
  logic [9:0] h_wake;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      h_ticks <= 7'h00;
      h_wake  <= 10'h000;
    end else begin
      if (s.state == ST_SYNC || done_w)
        h_ticks <= 7'h00;
      else if (tick && s.state != ST_IDLE)
        h_ticks <= h_ticks + 7'h01;
      if (s.state == ST_IDLE)
        h_wake <= 10'h000;
      else if (h_wake != 10'h3ff)
        h_wake <= h_wake + 10'h001;
    end
  end

  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);

  idle_quiet_a: assert property ( // RULE1
    s.state == ST_IDLE && $past(s.state) == ST_IDLE |-> !tick && !fe_active)
    else $error("activity while idle");
  sample_then_hold_a: assert property ( // RULE4
    $fell(fe_sample) && s.state != ST_IDLE && !$past(abort_w)
    |-> s.state == ST_APPROX && fe_trial == 10'h200)
    else $error("approximation did not follow sampling");
  xfer_result_a: assert property ( // RULE5
    done_w && s.mode10 |=> s.conv_complete_flag && s.result == $past(s.trial))
    else $error("result not transferred at completion");
  first_short_a: assert property ( // RULE6
    done_w && s.first && !s.long_smp
    |-> h_ticks + 7'h01 == (s.mode10 ? 7'd23 : 7'd20))
    else $error("first short conversion tick count wrong");
  first_long_a: assert property ( // RULE7
    done_w && s.first && s.long_smp
    |-> h_ticks + 7'h01 == (s.mode10 ? 7'd43 : 7'd40))
    else $error("first long conversion tick count wrong");
  async_start_a: assert property ( // RULE8
    s.state == ST_WAKE && $past(s.state) == ST_WAKE && n.state == ST_SAMPLE
    && s.clk_sel == CLK_ASYNC |-> h_wake >= 10'(ASYNC_START_CYC))
    else $error("async start-up shorter than 5 us");
  sub_short_a: assert property ( // RULE9
    done_w && !s.first && !s.long_smp
    |-> h_ticks + 7'h01 == (s.mode10 ? 7'd20 : 7'd17))
    else $error("continuous short conversion tick count wrong");
  sub_long_a: assert property ( // RULE10
    done_w && !s.first && s.long_smp
    |-> h_ticks + 7'h01 == (s.mode10 ? 7'd40 : 7'd37))
    else $error("continuous long conversion tick count wrong");
  sample_len_a: assert property ( // RULE13
    s.state == ST_APPROX && $past(s.state) == ST_SAMPLE
    |-> s.cnt == sac_smp_ticks(s.long_smp))
    else $error("sample window length wrong");
  irq_req_a: assert property ( // RULE16
    $rose(s.ist[0]) |-> $past(s.ie) && s.conv_complete_flag ##1 irq || !s.imsk[0])
    else $error("completion interrupt not raised");
  abort_keep_a: assert property ( // RULE17
    wmode_w && s.state != ST_IDLE
    |=> s.state == ST_IDLE && $stable(s.result) && s.ist[1])
    else $error("mode write did not abort cleanly");
  stop_abort_a: assert property ( // RULE18
    s.lvl[1] && s.clk_sel != CLK_ASYNC && s.state != ST_IDLE
    |=> s.state == ST_IDLE)
    else $error("stop without async clock did not abort");
  sync_in_a: assert property ( // RULE19
    s.state == ST_WAKE && $past(s.state) == ST_SYNC
    |-> $past(s.state, 2) == ST_SYNC)
    else $error("start synchronisation too short");

  single_done_c: cover property (done_w && s.first && !s.cont);
  cont_done_c:   cover property (done_w && !s.first);
  abort_c:       cover property (abort_w && s.state == ST_APPROX);
  async_done_c:  cover property (done_w && s.clk_sel == CLK_ASYNC);

endmodule : sac_adc_ctrl

`default_nettype wire

// ### verilog/sac_clkgen.sv
// Purpose: conversion clock as a tick train derived from pclk
// Assumes: the asynchronous source is modelled as a pclk divider
// Notes:   ticks stop and the prescaler clears whenever run is low

`timescale 1ns/1ps
`default_nettype none

module sac_clkgen
  import sac_pkg::*;
#(
  parameter int ALT_DIV   = 4,
  parameter int ASYNC_DIV = 2
) (
  input  wire logic       pclk,         // bus clock
  input  wire logic       presetn,      // async reset, active low
  input  wire logic       run,          // converter active
  input  wire logic [1:0] clk_sel,      // input_clock_select
  input  wire logic [1:0] div_sel,      // clock_divide_select
  input  wire logic       low_power,    // low_power_conv_sel
  output logic            tick,         // one conversion_clock period
  output logic            async_en,     // async generator enabled
  output logic            async_ready   // async generator started
);

  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] start;
    logic       ready;
    logic       en;
    logic       tick;
  } sac_gen_type;

  sac_gen_type s;
  sac_gen_type n;

  function automatic logic [7:0] sac_period(input logic [1:0] sel,
                                            input logic [1:0] dv,
                                            input logic       lp);
    logic [7:0] base;
    logic [7:0] p;
    unique case (sel)
      CLK_BUS:   base = 8'h01;
      CLK_BUS2:  base = 8'h02;
      CLK_ALT:   base = 8'(ALT_DIV);
      CLK_ASYNC: base = 8'(ASYNC_DIV);
    endcase
    p = base << dv;
    // low power halves the top rate of the fastest setting
    if (lp && p == 8'h01) // RULE3
      p = 8'h02;
    return p;
  endfunction : sac_period

  always_comb begin
    n      = s;
    n.tick = 1'b0;
    n.en   = run && clk_sel == CLK_ASYNC; // RULE2
    if (!run) begin
      n.cnt   = 8'h00;
      n.start = 8'h00;
      n.ready = 1'b0;
    end else if (clk_sel == CLK_ASYNC && !s.ready) begin
      if (s.start == 8'(ASYNC_START_CYC - 1)) // RULE8
        n.ready = 1'b1;
      else
        n.start = s.start + 8'h01;
    end else if (s.cnt >= sac_period(clk_sel, div_sel, low_power) - 8'h01)
    begin
      n.cnt  = 8'h00; // RULE12
      n.tick = 1'b1;
    end else begin
      n.cnt = s.cnt + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      s <= '0;
    else
      s <= n;
  end

  assign tick        = s.tick;
  assign async_en    = s.en;
  assign async_ready = s.ready;

  async_en_a: assert property (@(posedge pclk) disable iff (!presetn)
    run && clk_sel == CLK_ASYNC |=> async_en) // RULE2
    else $error("async generator not enabled while active");

  low_power_a: assert property (@(posedge pclk) disable iff (!presetn)
    low_power && $stable(low_power) && tick |=> !tick) // RULE3
    else $error("back to back ticks in low power");

endmodule : sac_clkgen

`default_nettype wire

// ### verilog/sac_pkg.sv
// Purpose: shared constants and types of the converter sequencer
// Assumes: 32-bit APB words, one register per aligned word
// Notes:   tick counts are in conversion clock periods

package sac_pkg;

  localparam logic [7:0] SC1_OFF  = 8'h00;
  localparam logic [7:0] SC2_OFF  = 8'h04;
  localparam logic [7:0] CFG_OFF  = 8'h08;
  localparam logic [7:0] CMP_OFF  = 8'h0c;
  localparam logic [7:0] RESH_OFF = 8'h10;
  localparam logic [7:0] RESL_OFF = 8'h14;
  localparam logic [7:0] IST_OFF  = 8'h18;
  localparam logic [7:0] IMSK_OFF = 8'h1c;

  localparam int SC1_CONT_BIT = 5;
  localparam int SC1_IE_BIT   = 6;
  localparam int SC2_RDY_BIT  = 0;
  localparam int SC2_HWT_BIT  = 6;
  localparam int CFG_MODE_BIT = 2;
  localparam int CFG_LS_BIT   = 4;
  localparam int CFG_DIV_LSB  = 5;
  localparam int CFG_LP_BIT   = 7;

  localparam logic [4:0] CHAN_OFF  = 5'h1f;
  localparam logic [1:0] CLK_BUS   = 2'h0;
  localparam logic [1:0] CLK_BUS2  = 2'h1;
  localparam logic [1:0] CLK_ALT   = 2'h2;
  localparam logic [1:0] CLK_ASYNC = 2'h3;

  localparam int CLK_HZ          = 40_000_000;
  localparam int ASYNC_START_NS  = 5000;
  localparam int ASYNC_START_CYC =
    (ASYNC_START_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int START_SYNC_CYC  = 2;

  localparam logic [5:0] SHORT_SMP_TICKS   = 6'h04;
  localparam logic [5:0] LONG_SMP_TICKS    = 6'h18;
  localparam logic [5:0] SUB_8_SHORT       = 6'h11;
  localparam logic [5:0] SUB_10_SHORT      = 6'h14;
  localparam logic [5:0] SUB_8_LONG        = 6'h25;
  localparam logic [5:0] SUB_10_LONG       = 6'h28;
  localparam logic [5:0] FIRST_EXTRA_TICKS = 6'h03;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SYNC   = 3'b001,
    ST_WAKE   = 3'b010,
    ST_SAMPLE = 3'b011,
    ST_APPROX = 3'b100,
    ST_PAD    = 3'b101
  } sac_state_type;

  function automatic logic [5:0] sac_smp_ticks(input logic long_smp);
    return long_smp ? LONG_SMP_TICKS : SHORT_SMP_TICKS;
  endfunction : sac_smp_ticks

  function automatic logic [5:0] sac_sub_ticks(input logic mode10,
                                               input logic long_smp);
    if (long_smp)
      return mode10 ? SUB_10_LONG : SUB_8_LONG;
    return mode10 ? SUB_10_SHORT : SUB_8_SHORT;
  endfunction : sac_sub_ticks

endpackage : sac_pkg
